// ==== rtl/tpb_base_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpb_base_tick #(
  parameter int unsigned TICK_CYCLES = 100000
) (
  input wire logic core_clk,
  input wire logic reset_n,
  output logic baseTick
);
  import tpb_pkg::*;

  logic [31:0] count_reg;
  logic atEnd;

  assign atEnd = (count_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_reg <= 32'h00000000;
      baseTick <= 1'b0;
    end else begin
      count_reg <= atEnd ? 32'h00000000 : count_reg + 32'h00000001;
      baseTick <= atEnd;
    end
  end

endmodule : tpb_base_tick
`default_nettype wire

// ==== rtl/tpb_pkg.sv ====
package tpb_pkg;

  // Base tick and clock rate
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BASE_TICK_NS = 1000000;
  localparam int unsigned BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;

  // Base ticks per count of each time unit
  localparam logic [21:0] UNIT_MS_MUL = 22'h000001;
  localparam logic [21:0] UNIT_S_MUL = 22'h0003E8;
  localparam logic [21:0] UNIT_MIN_MUL = 22'h00EA60;
  localparam logic [21:0] UNIT_H_MUL = 22'h36EE80;

  typedef enum logic [1:0] {
    UNIT_MS = 2'h0,
    UNIT_S = 2'h1,
    UNIT_MIN = 2'h2,
    UNIT_H = 2'h3
  } tpb_unit_t;

  typedef enum logic [2:0] {
    CP_SECOND = 3'h0,
    CP_TEN_SEC = 3'h1,
    CP_MINUTE = 3'h2,
    CP_HOUR = 3'h3,
    CP_DAY = 3'h4
  } tpb_clock_mode_t;

  // Register byte addresses
  localparam logic [7:0] ADDR_RET_CFG = 8'h00;
  localparam logic [7:0] ADDR_PULSE_CFG = 8'h04;
  localparam logic [7:0] ADDR_SQUARE_CFG = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_CFG = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_RET_TIME = 8'h14;
  localparam logic [7:0] ADDR_PULSE_TIME = 8'h18;
  localparam logic [7:0] ADDR_SQUARE_TIME = 8'h1C;

  // Field positions
  localparam int unsigned CFG_TIME_LSB = 0;
  localparam int unsigned CFG_UNIT_LSB = 16;
  localparam int unsigned CLK_MODE_LSB = 0;
  localparam int unsigned CLK_EN_BIT = 3;

  // Reset values
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] CLOCK_CFG_RESET = 32'h00000000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic connected;
    logic [15:0] value;
  } tpb_time_in_t;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } tpb_rtc_t;

  function automatic logic [21:0] unitMultiple(input logic [1:0] unit);
    unique case (unit)
      UNIT_MS: unitMultiple = UNIT_MS_MUL;
      UNIT_S: unitMultiple = UNIT_S_MUL;
      UNIT_MIN: unitMultiple = UNIT_MIN_MUL;
      default: unitMultiple = UNIT_H_MUL;
    endcase
  endfunction : unitMultiple

endpackage : tpb_pkg

// ==== rtl/tpb_span_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpb_span_timer (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic baseTick,
  input wire logic clear,
  input wire logic run,
  input wire logic [21:0] unitMul,
  input wire logic [15:0] limit,
  output logic done
);
  import tpb_pkg::*;

  logic [21:0] sub_reg;
  logic [15:0] main_reg;
  logic atLimit;
  logic subWrap;

  // Compare with >= so a lowered limit still ends the span
  assign atLimit = (main_reg >= limit);
  assign subWrap = (sub_reg == unitMul - 22'h000001);
  // Clear kept out of done: square timer clears on done
  assign done = run & atLimit;

  always_ff @(posedge core_clk) begin
    if (!reset_n || clear) begin
      sub_reg <= 22'h000000;
      main_reg <= 16'h0000;
    end else if (run && baseTick && !atLimit) begin
      sub_reg <= subWrap ? 22'h000000 : sub_reg + 22'h000001;
      main_reg <= subWrap ? main_reg + 16'h0001 : main_reg;
    end
  end

endmodule : tpb_span_timer
`default_nettype wire

// ==== rtl/tpb_timer_blocks.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpb_timer_blocks #(
  parameter int unsigned TICK_CYCLES = tpb_pkg::BASE_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic retTrigger,
  input wire logic retClear,
  input wire tpb_pkg::tpb_time_in_t retTime,
  input wire logic pulseTrigger,
  input wire tpb_pkg::tpb_time_in_t pulseTime,
  input wire logic squareEnable,
  input wire tpb_pkg::tpb_time_in_t squareTime,
  input wire tpb_pkg::tpb_rtc_t rtcNow,
  output logic retentiveDelayOut,
  output logic pulseRelayOut,
  output logic squareWaveOut,
  output logic clockPulseOut
);
  import tpb_pkg::*;
  typedef enum logic [1:0] {
    SQ_LOW = 2'b01,
    SQ_HIGH = 2'b10
  } tpb_sq_state_t;

  // Writable cfg words 0..3, read-only words 4..7
  function automatic logic isWritable(input logic [7:0] addr);
    isWritable = (addr[7:4] == 4'h0) && (addr[1:0] == 2'h0);
  endfunction : isWritable
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0);
  endfunction : isMapped
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      mergeBytes[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : mergeBytes
  // Bus slave state
  logic awHeld_reg;
  logic [7:0] awAddr_reg;
  logic wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  logic [31:0] cfg_reg [4];
  logic doWrite;
  logic doRead;
  logic [31:0] readWord;
  logic [31:0] statusWord;
  // Block state
  logic baseTick;
  logic retClearPrev_reg;
  logic retClearRise;
  logic retLatched_reg;
  logic retRun;
  logic retTimerClear;
  logic retDone;
  logic pulseTrigPrev_reg;
  logic pulseRise;
  logic pulseActive_reg;
  logic pulseDone;
  tpb_sq_state_t sqState_reg;
  tpb_sq_state_t sqState_next;
  logic sqDone;
  logic sqTimerClear;
  logic [5:0] secondPrev_reg;
  logic rtcPrimed_reg;
  logic secondChanged;
  logic modeMatch;
  logic clockEvent;
  logic clockPulse_reg;
  logic [15:0] retLimit;
  logic [15:0] pulseLimit;
  logic [15:0] squareLimit;
  logic [21:0] retUnitMul;
  logic [21:0] pulseUnitMul;
  logic [21:0] squareUnitMul;
  logic [2:0] clockMode;
  logic clockEnable;
  // Write address and data taken in either order
  assign s_axi_awready = ~awHeld_reg;
  assign s_axi_wready = ~wHeld_reg;
  assign doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = ~rValid_reg;
  assign doRead = s_axi_arvalid & ~rValid_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
    end else if (s_axi_awvalid && !awHeld_reg) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else if (s_axi_wvalid && !wHeld_reg) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  // Read-only words accept writes silently; holes answer SLVERR
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bValid_reg <= 1'b0;
      bResp_reg <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg <= isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_reg <= 1'b0;
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : gCfg
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          cfg_reg[g] <= (g == 3) ? CLOCK_CFG_RESET : CFG_RESET;
        end else if (doWrite && isWritable(awAddr_reg) &&
            awAddr_reg[3:2] == 2'(g)) begin
          cfg_reg[g] <= mergeBytes(cfg_reg[g], wData_reg, wStrb_reg);
        end
      end
    end
  endgenerate

  assign statusWord = {24'h000000, rtcPrimed_reg, sqState_reg == SQ_HIGH,
      pulseActive_reg, retLatched_reg, clockPulse_reg, squareWaveOut,
      pulseRelayOut, retentiveDelayOut};

  assign readWord = (s_axi_araddr == ADDR_RET_CFG) ? cfg_reg[0] :
      (s_axi_araddr == ADDR_PULSE_CFG) ? cfg_reg[1] :
      (s_axi_araddr == ADDR_SQUARE_CFG) ? cfg_reg[2] :
      (s_axi_araddr == ADDR_CLOCK_CFG) ? cfg_reg[3] :
      (s_axi_araddr == ADDR_STATUS) ? statusWord :
      (s_axi_araddr == ADDR_RET_TIME) ? {16'h0000, retLimit} :
      (s_axi_araddr == ADDR_PULSE_TIME) ? {16'h0000, pulseLimit} :
      (s_axi_araddr == ADDR_SQUARE_TIME) ? {16'h0000, squareLimit} :
      32'h00000000;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h00000000;
      rResp_reg <= RESP_OKAY;
    end else if (doRead) begin
      rValid_reg <= 1'b1;
      rData_reg <= readWord;
      rResp_reg <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_reg <= 1'b0;
    end
  end

  // Time and unit selection
  assign retLimit = retTime.connected ? retTime.value :
      cfg_reg[0][CFG_TIME_LSB +: 16];
  assign pulseLimit = pulseTime.connected ? pulseTime.value :
      cfg_reg[1][CFG_TIME_LSB +: 16];
  assign squareLimit = squareTime.connected ? squareTime.value :
      cfg_reg[2][CFG_TIME_LSB +: 16];
  assign retUnitMul = unitMultiple(cfg_reg[0][CFG_UNIT_LSB +: 2]);
  assign pulseUnitMul = unitMultiple(cfg_reg[1][CFG_UNIT_LSB +: 2]);
  assign squareUnitMul = unitMultiple(cfg_reg[2][CFG_UNIT_LSB +: 2]);
  assign clockMode = cfg_reg[3][CLK_MODE_LSB +: 3];
  assign clockEnable = cfg_reg[3][CLK_EN_BIT];

  // One divider shared by every timer
  tpb_base_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) uBaseTick (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .baseTick(baseTick)
  );

  // Retentive on-delay
  assign retClearRise = retClear & ~retClearPrev_reg;
  assign retRun = retTrigger & ~retLatched_reg & ~retClearRise;
  assign retTimerClear = ~retRun;

  tpb_span_timer uRetTimer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .baseTick(baseTick),
    .clear(retTimerClear),
    .run(retRun),
    .unitMul(retUnitMul),
    .limit(retLimit),
    .done(retDone)
  );

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      retClearPrev_reg <= 1'b0;
      retLatched_reg <= 1'b0;
    end else begin
      retClearPrev_reg <= retClear;
      if (retClearRise) begin
        retLatched_reg <= 1'b0;
      end else if (retDone) begin
        retLatched_reg <= 1'b1;
      end
    end
  end

  assign retentiveDelayOut = retLatched_reg;

  // Pulse relay: output rises on the trigger edge, drops after the set time or when the trigger falls
  assign pulseRise = pulseTrigger & ~pulseTrigPrev_reg;

  tpb_span_timer uPulseTimer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .baseTick(baseTick),
    .clear(~pulseActive_reg),
    .run(pulseActive_reg),
    .unitMul(pulseUnitMul),
    .limit(pulseLimit),
    .done(pulseDone)
  );

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pulseTrigPrev_reg <= 1'b0;
      pulseActive_reg <= 1'b0;
    end else begin
      pulseTrigPrev_reg <= pulseTrigger;
      if (!pulseTrigger) begin
        pulseActive_reg <= 1'b0;
      end else if (pulseRise) begin
        pulseActive_reg <= 1'b1;
      end else if (pulseDone) begin
        pulseActive_reg <= 1'b0;
      end
    end
  end

  // Combinational so the edge shows in its own cycle
  assign pulseRelayOut = pulseTrigger &
      (pulseRise | pulseActive_reg);

  // Square wave; timer restarts on each phase change
  assign sqTimerClear = ~squareEnable | sqDone;

  tpb_span_timer uSquareTimer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .baseTick(baseTick),
    .clear(sqTimerClear),
    .run(squareEnable),
    .unitMul(squareUnitMul),
    .limit(squareLimit),
    .done(sqDone)
  );
  always_comb begin
    sqState_next = sqState_reg;
    unique case (sqState_reg)
      SQ_LOW: sqState_next = sqDone ? SQ_HIGH : SQ_LOW;
      SQ_HIGH: sqState_next = sqDone ? SQ_LOW : SQ_HIGH;
      default: sqState_next = SQ_LOW;
    endcase
    if (!squareEnable) begin
      sqState_next = SQ_LOW;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sqState_reg <= SQ_LOW;
    end else begin
      sqState_reg <= sqState_next;
    end
  end

  assign squareWaveOut = (sqState_reg == SQ_HIGH);

  // Real-time pulses; seconds field changes mark clock events
  assign secondChanged = rtcPrimed_reg &&
      (rtcNow.second != secondPrev_reg);

  // Match on field values, not elapsed time, for alignment
  assign modeMatch =
      (clockMode == CP_SECOND) ? 1'b1 :
      (clockMode == CP_TEN_SEC) ? (rtcNow.second % 6'd10 == 6'd0) :
      (clockMode == CP_MINUTE) ? (rtcNow.second == 6'd0) :
      (clockMode == CP_HOUR) ? (rtcNow.second == 6'd0 &&
          rtcNow.minute == 6'd0) :
      (clockMode == CP_DAY) ? (rtcNow.second == 6'd0 &&
          rtcNow.minute == 6'd0 && rtcNow.hour == 5'd0) :
      1'b0;

  assign clockEvent = clockEnable & secondChanged & modeMatch;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      secondPrev_reg <= 6'h00;
      rtcPrimed_reg <= 1'b0;
      clockPulse_reg <= 1'b0;
    end else begin
      secondPrev_reg <= rtcNow.second;
      rtcPrimed_reg <= 1'b1;
      clockPulse_reg <= clockEvent;
    end
  end

  assign clockPulseOut = clockPulse_reg;

endmodule : tpb_timer_blocks
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpb_pkg::*;
  localparam int TK = 2;
  logic core_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, retTrigger, retClear;
  logic pulseTrigger, squareEnable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd, lfsr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] resp;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [3:0] outs;
  wire tpb_rtc_t rtcNow;
  tpb_time_in_t retTime, pulseTime, squareTime;
  int miscompares, total_checks, n, cnt, per;
  tpb_timer_blocks #(.TICK_CYCLES(TK)) tpb_timer_blocks_inst (
    .core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .retTrigger(retTrigger),
    .retClear(retClear), .retTime(retTime), .pulseTrigger(pulseTrigger),
    .pulseTime(pulseTime), .squareEnable(squareEnable),
    .squareTime(squareTime), .rtcNow(rtcNow),
    .retentiveDelayOut(outs[0]), .pulseRelayOut(outs[1]),
    .squareWaveOut(outs[2]), .clockPulseOut(outs[3]));
  tpb_logic_partner #(.SEC_CYCLES(2)) tpb_logic_partner_inst (
    .core_clk(core_clk), .reset_n(reset_n), .rtcNow(rtcNow));
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk
  task automatic tmo();
    chk(1'b0, "wait timed out");
    close_out();
  endtask : tmo
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) tmo();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    bit done;
    done = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) tmo();
  endtask : axi_rd
  // Bounded: a stuck output must not hang the run
  task automatic waitOut(input int sel, input logic v, output int k);
    k = 0;
    while (outs[sel] !== v && k < 9000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 9000) tmo();
  endtask : waitOut
  // Span starts at any tick phase, so allow one tick short
  function automatic logic inRange(input int k, input int t, input int mul);
    return k >= (t * mul - 1) * TK - 1 && k <= t * mul * TK + 3;
  endfunction : inRange
  function automatic logic [31:0] nextRnd(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nextRnd
  function automatic logic aligned(input int m, input tpb_rtc_t t);
    if (m == 0) return 1'b1;
    if (m == 1) return t.second % 10 == 0;
    return t.second == 6'h00;
  endfunction : aligned
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, retTrigger, retClear} = '0;
    {pulseTrigger, squareEnable, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, retTime, pulseTime, squareTime} = '0;
    s_axi_wstrb = 4'hF;
    lfsr = 32'h131C4FE1;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    axi_rd(ADDR_RET_CFG);
    chk(rd === CFG_RESET, "config reset value");
    axi_rd(8'h40);
    chk(resp === RESP_SLVERR, "unmapped read accepted");
    axi_wr(8'h40, 32'h0000FFFF);
    chk(resp === RESP_SLVERR, "unmapped write accepted");
    lfsr = nextRnd(lfsr);
    retTime <= {1'b1, lfsr[15:0]};
    axi_rd(ADDR_RET_TIME);
    chk(rd[15:0] === lfsr[15:0], "connected time ignored");
    retTime <= '0;
    for (int u = 0; u < 2; u++) begin
      axi_wr(ADDR_RET_CFG, {14'h0000, 2'(u), 16'h0001});
      chk(resp === RESP_OKAY, "write response");
      axi_rd(ADDR_RET_TIME);
      chk(rd[15:0] === 16'h0001, "stored time");
      retTrigger <= 1'b1;
      waitOut(0, 1'b1, n);
      chk(inRange(n, 1, u ? 1000 : 1), "retentive delay");
      @(posedge core_clk) retTrigger <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1 chk(outs[0] === 1'b1, "retentive hold");
      @(posedge core_clk) retClear <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk(outs[0] === 1'b0, "retentive clear");
      @(posedge core_clk) retClear <= 1'b0;
    end
    lfsr = nextRnd(lfsr);
    cnt = int'(lfsr[1:0]) + 2;
    @(posedge core_clk) pulseTime <= {1'b1, 16'(cnt)};
    @(posedge core_clk) pulseTrigger <= 1'b1;
    #1 chk(outs[1] === 1'b1, "relay edge");
    waitOut(1, 1'b0, n);
    chk(inRange(n, cnt, 1) && pulseTrigger, "relay length");
    @(posedge core_clk) pulseTrigger <= 1'b0;
    pulseTime <= {1'b1, 16'h0040};
    @(posedge core_clk) pulseTrigger <= 1'b1;
    repeat (3) @(posedge core_clk);
    pulseTrigger <= 1'b0;
    #1 chk(outs[1] === 1'b0, "relay cut short");
    axi_wr(ADDR_SQUARE_CFG, 32'h00000003);
    @(posedge core_clk) squareEnable <= 1'b1;
    #1 chk(outs[2] === 1'b0, "square start");
    waitOut(2, 1'b1, n);
    chk(inRange(n, 3, 1), "square low phase");
    waitOut(2, 1'b0, n);
    chk(inRange(n, 3, 1), "square high phase");
    waitOut(2, 1'b1, n);
    @(posedge core_clk) squareEnable <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(outs[2] === 1'b0, "square off");
    @(posedge core_clk) squareEnable <= 1'b1;
    waitOut(2, 1'b1, n);
    chk(inRange(n, 3, 1), "square restart low phase");
    // Last pass uses a mode code that must never fire
    for (int m = 0; m < 4; m++) begin
      axi_wr(ADDR_CLOCK_CFG, 32'h00000008 | 32'(m == 3 ? 5 : m));
      per = (m == 0) ? 1 : (m == 1) ? 10 : 60;
      cnt = 0;
      repeat (260) begin
        @(posedge core_clk);
        #1;
        if (outs[3] === 1'b1) begin
          cnt++;
          chk(aligned(m, rtcNow), "pulse off boundary");
        end
      end
      n = (m == 3) ? 0 : 130 / per;
      chk((m == 3) ? cnt == 0 : (cnt >= n - 1 && cnt <= n + 1),
          "clock pulse count");
    end
    close_out();
  end
endmodule : tb
bind tpb_timer_blocks tpb_timer_blocks_assertions
  tpb_timer_blocks_assertions_inst (
  .core_clk(core_clk), .reset_n(reset_n), .retTrigger(retTrigger),
  .retClear(retClear), .pulseTrigger(pulseTrigger),
  .squareEnable(squareEnable), .rtcNow(rtcNow),
  .retentiveDelayOut(retentiveDelayOut), .pulseRelayOut(pulseRelayOut),
  .squareWaveOut(squareWaveOut), .clockPulseOut(clockPulseOut));
`default_nettype wire

// ==== tb/tpb_logic_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// Fast real-time clock; a real one ticks once a second
module tpb_logic_partner #(
  parameter int unsigned SEC_CYCLES = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  output tpb_pkg::tpb_rtc_t rtcNow
);
  import tpb_pkg::*;
  logic [7:0] cnt_reg;
  tpb_rtc_t rtc_reg;
  tpb_rtc_t rtc_next;
  wire logic wrap = cnt_reg == 8'(SEC_CYCLES - 1);
  wire logic secWrap = rtc_reg.second == 6'h3B;
  wire logic minWrap = rtc_reg.minute == 6'h3B;
  wire logic hourWrap = rtc_reg.hour == 5'h17;
  assign rtc_next.second = secWrap ? 6'h00 : rtc_reg.second + 6'h01;
  assign rtc_next.minute = !secWrap ? rtc_reg.minute :
    (minWrap ? 6'h00 : rtc_reg.minute + 6'h01);
  assign rtc_next.hour = !(secWrap && minWrap) ? rtc_reg.hour :
    (hourWrap ? 5'h00 : rtc_reg.hour + 5'h01);
  assign rtcNow = rtc_reg;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_reg <= 8'h00;
      rtc_reg <= '0;
    end else begin
      cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
      if (wrap) rtc_reg <= rtc_next;
    end
  end
endmodule : tpb_logic_partner
`default_nettype wire

// ==== tb/tpb_timer_blocks_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpb_timer_blocks_assertions (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic retTrigger,
  input wire logic retClear,
  input wire logic pulseTrigger,
  input wire logic squareEnable,
  input wire tpb_pkg::tpb_rtc_t rtcNow,
  input wire logic retentiveDelayOut,
  input wire logic pulseRelayOut,
  input wire logic squareWaveOut,
  input wire logic clockPulseOut
);
  import tpb_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence clearEdge;
    $rose(retClear);
  endsequence
  // Pulse lags the seconds change by one cycle
  sequence secondMoved;
    $past(rtcNow.second) != $past(rtcNow.second, 2);
  endsequence
  a_ret_cause: assert property ($rose(retentiveDelayOut) |->
    $past(retTrigger)) else $error("retentive out rose untriggered");
  a_ret_hold: assert property (retentiveDelayOut && !$rose(retClear)
    |=> retentiveDelayOut) else $error("retentive out dropped");
  a_ret_clear: assert property (clearEdge |=> !retentiveDelayOut)
    else $error("clear edge ignored");
  a_relay_edge: assert property ($rose(pulseTrigger) |-> pulseRelayOut)
    else $error("relay missed trigger edge");
  a_relay_once: assert property ($rose(pulseRelayOut) |->
    $rose(pulseTrigger)) else $error("relay rose without edge");
  a_relay_low: assert property (!pulseTrigger |-> !pulseRelayOut)
    else $error("relay high with trigger low");
  a_square_enabled: assert property ($rose(squareWaveOut) |->
    $past(squareEnable)) else $error("square rose while disabled");
  a_square_off: assert property (!squareEnable |=> !squareWaveOut)
    else $error("square high while disabled");
  a_clock_rtc: assert property (clockPulseOut |-> secondMoved)
    else $error("clock pulse without seconds change");
  a_clock_single: assert property (clockPulseOut |=> !clockPulseOut)
    else $error("clock pulse longer than a cycle");
endmodule : tpb_timer_blocks_assertions
`default_nettype wire
